// [cpms_control_pin_mode_select.v]
// Control pin interpretation, serial programming port and Wishbone status view
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpms_defs.vh"

// What this block does
// - With the reset pin low, the serial clock pin clocks the serial programming port.
// - With the reset pin high, serial clock and data pins select lane_alignment_mode, sync or power down.
// - With the reset pin low, the serial data pin carries the serial programming data.
// - With the reset pin low, the serial enable pin frames serial programming words.
// - With the reset pin high, the serial enable level selects coarse gain and reference.
// - The first configuration pin selects one or two lanes and the bit clock rate.
// - The second configuration pin selects 12x or 14x and the single-rate capture edge.
// - The power-down pin powers the device down regardless of the serial port.
// - Undriven, serial enable reads high and serial clock, data and reset read low.
module cpms_control_pin_mode_select #(
  parameter NREG = 32
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Control pins, each with a driven flag except the power-down pin
  input wire prog_clk_pin_i,
  input wire prog_clk_pin_drv_i,
  input wire prog_data_pin_i,
  input wire prog_data_pin_drv_i,
  input wire prog_enable_pin_i,
  input wire prog_enable_pin_drv_i,
  input wire prog_reset_pin_i,
  input wire prog_reset_pin_drv_i,
  input wire global_powerdown_pin_i,
  // Configuration pin level codes
  input wire [1:0] lane_and_clock_rate_select_i,
  input wire [1:0] serialization_and_edge_select_i,
  // Decoded modes
  output reg serial_mode_o,
  output reg lane_alignment_mode_o,
  output reg sync_mode_o,
  output reg powerdown_o,
  output reg coarse_gain_o,
  output reg ext_ref_o,
  output reg two_wire_o,
  output reg ddr_clk_o,
  output reg ser14x_o,
  output reg sdr_fall_edge_o
);
  localparam NPIN = 9;
  localparam [7:0] NREG_M1 = NREG[7:0] - 8'd1;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;
  reg [NPIN-1:0] meta_ff;
  reg [NPIN-1:0] sync_ff;
  reg sclk_d_ff;
  reg rst_d_ff;
  reg [15:0] shift_ff;
  reg [4:0] cnt_ff;
  reg [`CPMS_DATA_W-1:0] prog_reg_ff [0:NREG-1];
  reg [4:0] idx_ff;
  reg swrst_ff;
  reg [1:0] lane_and_clock_rate_select_q;
  reg [1:0] serialization_and_edge_select_q;
  reg [1:0] par_sel;
  reg [31:0] nxt_dat;
  wire [15:0] nxt_shift;
  wire sclk_rise;
  wire frame_done;
  wire serial_mode;
  wire hw_rst_pulse;
  wire cmd_rst;
  wire clr_regs;
  wire wb_req;
  wire wb_wr;
  integer i;

  // Undriven pins fall back to their pull levels
  assign pin_raw[0] = prog_clk_pin_drv_i ? prog_clk_pin_i : `CPMS_PULL_SCLK;
  assign pin_raw[1] = prog_data_pin_drv_i ? prog_data_pin_i : `CPMS_PULL_PROG_DATA_PIN;
  assign pin_raw[2] = prog_enable_pin_drv_i ? prog_enable_pin_i : `CPMS_PULL_SEN;
  assign pin_raw[3] = prog_reset_pin_drv_i ? prog_reset_pin_i : `CPMS_PULL_RST;
  assign pin_raw[4] = global_powerdown_pin_i;
  assign pin_raw[6:5] = lane_and_clock_rate_select_i;
  assign pin_raw[8:7] = serialization_and_edge_select_i;

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= pin_raw[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate
  assign pin_s = sync_ff;

  assign serial_mode = ~pin_s[3];
  assign sclk_rise = serial_mode & pin_s[0] & ~sclk_d_ff;
  assign nxt_shift = {shift_ff[14:0], pin_s[1]};
  assign frame_done = sclk_rise & ~pin_s[2] & (cnt_ff == `CPMS_FRAME_BITS - 5'd1);
  assign hw_rst_pulse = pin_s[3] & ~rst_d_ff;
  assign cmd_rst = frame_done & (nxt_shift[15:11] == `CPMS_SWRST_ADDR) &
                   nxt_shift[`CPMS_SWRST_BIT];
  assign clr_regs = hw_rst_pulse | cmd_rst | swrst_ff;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Serial shifter, framed by the enable pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_ff <= 1'b0;
      rst_d_ff <= 1'b0;
      shift_ff <= 16'h0000;
      cnt_ff <= 5'd0;
    end else begin
      sclk_d_ff <= pin_s[0];
      rst_d_ff <= pin_s[3];
      if (!serial_mode || pin_s[2] || clr_regs) begin
        cnt_ff <= 5'd0;
      end else if (sclk_rise) begin
        shift_ff <= nxt_shift;
        cnt_ff <= frame_done ? 5'd0 : cnt_ff + 5'd1;
      end
    end
  end

  // Serial register file
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < NREG; i = i + 1) begin
        prog_reg_ff[i] <= `CPMS_REG_RESET;
      end
    end else if (clr_regs) begin
      for (i = 0; i < NREG; i = i + 1) begin
        prog_reg_ff[i] <= `CPMS_REG_RESET;
      end
    end else if (frame_done && ({3'b000, nxt_shift[15:11]} <= NREG_M1)) begin
      prog_reg_ff[nxt_shift[15:11]] <= nxt_shift[10:0];
    end
  end

  // Configuration pin decode
  always @* begin
    lane_and_clock_rate_select_q = pin_s[6:5];
    serialization_and_edge_select_q = pin_s[8:7];
    par_sel = {pin_s[0], pin_s[1]};
  end

  // Mode outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_o <= 1'b0;
      lane_alignment_mode_o <= 1'b0;
      sync_mode_o <= 1'b0;
      powerdown_o <= 1'b0;
      coarse_gain_o <= 1'b0;
      ext_ref_o <= 1'b0;
      two_wire_o <= 1'b0;
      ddr_clk_o <= 1'b0;
      ser14x_o <= 1'b0;
      sdr_fall_edge_o <= 1'b0;
    end else begin
      serial_mode_o <= serial_mode;
      lane_alignment_mode_o <= ~serial_mode & (par_sel == `CPMS_PAR_LANE_ALIGNMENT_MODE);
      sync_mode_o <= ~serial_mode & (par_sel == `CPMS_PAR_SYNC);
      powerdown_o <= pin_s[4] | (~serial_mode & (par_sel == `CPMS_PAR_PDN));
      if (serial_mode) begin
        coarse_gain_o <= prog_reg_ff[`CPMS_GAIN_ADDR][`CPMS_GAIN_BIT];
        ext_ref_o <= prog_reg_ff[`CPMS_GAIN_ADDR][`CPMS_EXTREF_BIT];
      end else begin
        coarse_gain_o <= ~pin_s[2];
        ext_ref_o <= ~pin_s[2];
      end
      two_wire_o <= (lane_and_clock_rate_select_q == `CPMS_LVL_VDD) | (lane_and_clock_rate_select_q == `CPMS_LVL_LOW);
      ddr_clk_o <= (lane_and_clock_rate_select_q == `CPMS_LVL_VDD) | (lane_and_clock_rate_select_q == `CPMS_LVL_GND);
      case (serialization_and_edge_select_q)
        `CPMS_LVL_GND, `CPMS_LVL_VDD: begin
          ser14x_o <= 1'b0;
          sdr_fall_edge_o <= 1'b0;
        end
        `CPMS_LVL_LOW: begin
          ser14x_o <= 1'b1;
          sdr_fall_edge_o <= 1'b0;
        end
        default: begin
          ser14x_o <= 1'b1;
          sdr_fall_edge_o <= 1'b1;
        end
      endcase
    end
  end

  // Wishbone read mux
  always @* begin
    nxt_dat = 32'h00000000;
    case (wb_adr_i)
      `CPMS_ADR_STATUS: nxt_dat = {22'h000000, sdr_fall_edge_o, ser14x_o, ddr_clk_o,
                                  two_wire_o, ext_ref_o, coarse_gain_o, powerdown_o,
                                  sync_mode_o, lane_alignment_mode_o, serial_mode_o};
      `CPMS_ADR_IDX: nxt_dat = {27'h0000000, idx_ff};
      `CPMS_ADR_DATA: nxt_dat = {21'h000000, prog_reg_ff[idx_ff]};
      `CPMS_ADR_PINS: nxt_dat = {23'h000000, pin_s};
      default: nxt_dat = 32'h00000000;
    endcase
  end

  // Wishbone slave: ack one cycle after the request, write at the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      idx_ff <= 5'd0;
      swrst_ff <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= (wb_req & ~wb_we_i & ~wb_ack_o) ? nxt_dat : 32'h00000000;
      swrst_ff <= wb_wr & (wb_adr_i == `CPMS_ADR_CTRL) & wb_dat_i[`CPMS_CTRL_SWRST];
      if (wb_wr && (wb_adr_i == `CPMS_ADR_IDX)) begin
        idx_ff <= wb_dat_i[4:0];
      end
    end
  end
endmodule
`default_nettype wire

// [cpms_defs.vh]
// Constants for the control pin mode select block
`ifndef CPMS_DEFS_VH
`define CPMS_DEFS_VH
// Wishbone register byte offsets
`define CPMS_ADR_STATUS 8'h00
`define CPMS_ADR_CTRL 8'h04
`define CPMS_ADR_IDX 8'h08
`define CPMS_ADR_DATA 8'h0c
`define CPMS_ADR_PINS 8'h10
// Control register fields
`define CPMS_CTRL_SWRST 0
// Pull defaults of undriven pins
`define CPMS_PULL_SCLK 1'b0
`define CPMS_PULL_PROG_DATA_PIN 1'b0
`define CPMS_PULL_SEN 1'b1
`define CPMS_PULL_RST 1'b0
// Serial frame layout: 5 address bits then 11 data bits
`define CPMS_FRAME_BITS 5'd16
`define CPMS_ADDR_W 5
`define CPMS_DATA_W 11
`define CPMS_REG_RESET 11'h000
// Serial software reset command
`define CPMS_SWRST_ADDR 5'h00
`define CPMS_SWRST_BIT 1
// Serial gain and reference register
`define CPMS_GAIN_ADDR 5'h0a
`define CPMS_GAIN_BIT 0
`define CPMS_EXTREF_BIT 1
// Parallel decode of {serial clock, serial data}
`define CPMS_PAR_NORMAL 2'b00
`define CPMS_PAR_LANE_ALIGNMENT_MODE 2'b01
`define CPMS_PAR_SYNC 2'b10
`define CPMS_PAR_PDN 2'b11
// Configuration pin level codes
`define CPMS_LVL_GND 2'b00
`define CPMS_LVL_LOW 2'b01
`define CPMS_LVL_HIGH 2'b10
`define CPMS_LVL_VDD 2'b11
`endif

// [cpms_asserts.sv]
// Checker for the control pin mode select ports
`timescale 1ns/1ps
`default_nettype none
module cpms_asserts (
  // Clock, reset and bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // Pins
  input wire logic prog_clk_pin_i, prog_clk_pin_drv_i, prog_data_pin_i, prog_data_pin_drv_i,
  input wire logic prog_enable_pin_i, prog_enable_pin_drv_i, prog_reset_pin_i,
  input wire logic prog_reset_pin_drv_i, global_powerdown_pin_i,
  input wire logic [1:0] lane_and_clock_rate_select_i, serialization_and_edge_select_i,
  // Modes
  input wire logic serial_mode_o, lane_alignment_mode_o, sync_mode_o, powerdown_o,
  input wire logic coarse_gain_o, ext_ref_o, two_wire_o, ddr_clk_o, ser14x_o, sdr_fall_edge_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] age_ff;
  // Effective pin levels with pulls applied
  wire logic rs = prog_reset_pin_drv_i & prog_reset_pin_i;
  wire logic se = ~prog_enable_pin_drv_i | prog_enable_pin_i;
  wire logic [1:0] pr = {prog_clk_pin_drv_i & prog_clk_pin_i,
    prog_data_pin_drv_i & prog_data_pin_i};
  wire logic [1:0] c1 = lane_and_clock_rate_select_i;
  wire logic [1:0] c2 = serialization_and_edge_select_i;
  // Pipeline is full only some edges after reset
  wire logic up = age_ff == 3'h4;
  always_ff @(posedge clk_i) age_ff <= rst_i ? 3'h0 : age_ff + {2'h0, ~up};
  mode_a: assert property (up |-> serial_mode_o == !$past(rs, 3)) else $error("mode");
  lane_alignment_mode_a: assert property (up |-> lane_alignment_mode_o == ($past(rs, 3) &&
    $past(pr, 3) == 2'b01)) else $error("lane_alignment_mode");
  sync_a: assert property (up |-> sync_mode_o == ($past(rs, 3) &&
    $past(pr, 3) == 2'b10)) else $error("sync");
  pdn_a: assert property (up |-> powerdown_o == ($past(global_powerdown_pin_i, 3) ||
    ($past(rs, 3) && $past(pr, 3) == 2'b11))) else $error("powerdown");
  gain_a: assert property (up && $past(rs, 3) |-> coarse_gain_o == !$past(se, 3) &&
    ext_ref_o == coarse_gain_o) else $error("gain");
  lane_a: assert property (up |-> two_wire_o == $past(c1[0], 3) &&
    ddr_clk_o == !(^$past(c1, 3))) else $error("lanes");
  ser_a: assert property (up |-> ser14x_o == ^$past(c2, 3) &&
    sdr_fall_edge_o == ($past(c2, 3) == 2'b10)) else $error("serialization");
  ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack");
  cover property (lane_alignment_mode_o);
  cover property (serial_mode_o && coarse_gain_o);
  cover property (powerdown_o && sync_mode_o);
endmodule
bind cpms_control_pin_mode_select cpms_asserts u_chk (.*);
`default_nettype wire

// [cpms_host_model.sv]
// Host model driving the serial and mode pins
`timescale 1ns/1ps
`default_nettype none
module cpms_host_model (
  // Clock
  input wire logic clk_i,
  // Pin levels and driven flags
  output logic sclk_o, sclk_drv_o, prog_data_pin_o, prog_data_pin_drv_o,
  output logic sen_o, sen_drv_o, rst_o, rst_drv_o
);
  initial begin
    {rst_o, sen_o, sclk_o, prog_data_pin_o} = 4'b0100;
    {rst_drv_o, sen_drv_o, sclk_drv_o, prog_data_pin_drv_o} = 4'h0;
  end
  // Order is {reset, enable, clock, data}
  task automatic drive(input logic [3:0] v);
    @(posedge clk_i);
    {rst_o, sen_o, sclk_o, prog_data_pin_o} <= v;
    {rst_drv_o, sen_drv_o, sclk_drv_o, prog_data_pin_drv_o} <= 4'hf;
  endtask
  task automatic hold(input logic [3:0] v);
    drive(v);
    repeat (3) @(posedge clk_i);
  endtask
  // Undriven pins sit at their pull levels
  task automatic float_pins;
    @(posedge clk_i);
    {rst_o, sen_o, sclk_o, prog_data_pin_o} <= 4'b0100;
    {rst_drv_o, sen_drv_o, sclk_drv_o, prog_data_pin_drv_o} <= 4'h0;
  endtask
  // Low first, so the reset pin really rises even when it was high before
  task automatic pulse;
    hold(4'b0100);
    hold(4'b1100);
    hold(4'b0100);
  endtask
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      hold({3'b000, w[i]});
      hold({3'b001, w[i]});
    end
    hold(4'b0100);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the control pin mode select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0, global_powerdown_pin_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [1:0] lane_and_clock_rate_select_i = 2'b11, serialization_and_edge_select_i = 2'b00;
  logic wb_ack_o, prog_clk_pin_i, prog_clk_pin_drv_i, prog_data_pin_i, prog_data_pin_drv_i;
  logic prog_enable_pin_i, prog_enable_pin_drv_i, prog_reset_pin_i, prog_reset_pin_drv_i;
  logic serial_mode_o, lane_alignment_mode_o, sync_mode_o, powerdown_o, coarse_gain_o;
  logic ext_ref_o, two_wire_o, ddr_clk_o, ser14x_o, sdr_fall_edge_o;
  int errors = 0, samples_checked = 0;
  always #5 clk_i = ~clk_i;
  cpms_host_model host (.clk_i(clk_i), .sclk_o(prog_clk_pin_i), .sclk_drv_o(prog_clk_pin_drv_i),
    .prog_data_pin_o(prog_data_pin_i), .prog_data_pin_drv_o(prog_data_pin_drv_i), .sen_o(prog_enable_pin_i),
    .sen_drv_o(prog_enable_pin_drv_i), .rst_o(prog_reset_pin_i), .rst_drv_o(prog_reset_pin_drv_i));
  cpms_control_pin_mode_select uut (.*, .wb_stb_i(wb_cyc_i));
  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {1'b1, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    repeat (5) @(posedge clk_i);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic t_pull;
    host.float_pins();
    rd(8'h10);
    check("pins", q, 32'h064);
    rd(8'h00);
    check("status", q, 32'h0c1);
  endtask
  task automatic t_par;
    for (int v = 0; v < 16; v++) begin
      global_powerdown_pin_i <= v[3];
      host.drive({1'b1, v[2:0]});
      rd(8'h00);
      check("par", q, {22'h0, 4'b0011, ~v[2], ~v[2], v[3] | (&v[1:0]),
        v[1:0] == 2'b10, v[1:0] == 2'b01, 1'b0});
    end
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 16; i++) begin
      {lane_and_clock_rate_select_i, serialization_and_edge_select_i} <= i[3:0];
      rd(8'h00);
      check("cfg", {28'h0, q[9:6]}, {28'h0, i[1:0] == 2'b10, ^i[1:0], i[3] ~^ i[2], i[2]});
    end
  endtask
  task automatic t_ser;
    host.pulse();
    for (int k = 0; k < 3; k++) begin
      host.send({5'h0a, 11'h003});
      rd(8'h00);
      check("gain", {30'h0, q[5:4]}, 32'h3);
      wb(1'b1, 8'h08, 32'h0a);
      rd(8'h0c);
      check("reg", q, 32'h003);
      if (k == 0) wb(1'b1, 8'h04, 32'h1);
      else if (k == 1) host.send(16'h0002);
      else host.pulse();
      rd(8'h0c);
      check("clear", q, 32'h0);
    end
    rd(8'h20);
    check("unmapped", q, 32'h0);
  endtask
  task automatic print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_pull;
    t_par;
    t_cfg;
    t_ser;
    print_verdict;
  end
  initial begin
    #300000;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
